// [rtl/quad_dac_load_regs.vh]
`ifndef QUAD_DAC_LOAD_REGS_VH
`define QUAD_DAC_LOAD_REGS_VH
// frame layout, bit positions within the 16-bit word
`define FRAME_BITS 16
`define LOAD_HI_POS 15
`define LOAD_LO_POS 14
`define PICK_HI_POS 13
`define PICK_LO_POS 12
`define WORD_MSB 11
// sleep command fields
`define SLEEP_ALL_POS 11
`define SLEEP_CHAN_HI 10
`define SLEEP_CHAN_LO 9
`define SLEEP_MODE_HI 8
`define SLEEP_MODE_LO 7
// sleep termination codes
`define TERM_HIZ 2'h0
`define TERM_1K 2'h1
`define TERM_100K 2'h2
// reset values
`define CODE_RESET 12'h000
`define SLEEP_RESET 1'b0
// register bus map (byte addresses)
`define ADDR_INPUT_A 12'h000
`define ADDR_DAC_A 12'h010
`define ADDR_STATUS 12'h020
`define ADDR_CTRL 12'h024
`define ADDR_LAST 12'h028
`endif

// [rtl/serial_frame_rx.v]
`default_nettype none
// shifts in one frame on falling edges of the synchronised serial clock
module serial_frame_rx #(
  parameter BITS = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire sclk_i,
  input wire frame_strobe_n_i,
  input wire din_i,
  output reg frame_valid_o,
  output reg [BITS-1:0] frame_o
);
  reg [2:0] sclk_sync_reg;
  reg [1:0] fs_sync_reg;
  reg [1:0] din_sync_reg;
  reg [BITS-1:0] shift_reg;
  reg [4:0] count_reg;
  wire fall = sclk_sync_reg[2] & ~sclk_sync_reg[1];
  wire active = ~fs_sync_reg[1];

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_sync_reg <= 3'h0;
      fs_sync_reg <= 2'h3;
      din_sync_reg <= 2'h0;
      shift_reg <= {BITS{1'b0}};
      count_reg <= 5'h00;
      frame_valid_o <= 1'b0;
      frame_o <= {BITS{1'b0}};
    end else if (ce_i) begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
      fs_sync_reg <= {fs_sync_reg[0], frame_strobe_n_i};
      din_sync_reg <= {din_sync_reg[0], din_i};
      frame_valid_o <= 1'b0;
      if (!active) begin
        count_reg <= 5'h00; // high strobe restarts framing
      end else if (fall && count_reg < BITS) begin
        shift_reg <= {shift_reg[BITS-2:0], din_sync_reg[1]}; // msb first
        count_reg <= count_reg + 5'h01;
        if (count_reg == BITS - 1) begin
          frame_valid_o <= 1'b1;
          frame_o <= {shift_reg[BITS-2:0], din_sync_reg[1]};
        end
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/quad_dac_serial_load_control.v]
`include "quad_dac_load_regs.vh"
`default_nettype none
module quad_dac_serial_load_control #(
  parameter CODE_W = 12
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire sclk_i,
  input wire frame_strobe_n_i,
  input wire din_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  output reg [4*CODE_W-1:0] dac_code_o,
  output reg [3:0] sleep_o,
  output reg [7:0] term_o
);
  reg [CODE_W-1:0] input_mem [0:3];
  reg [CODE_W-1:0] dac_mem [0:3];
  reg [1:0] term_mem [0:3];
  reg [3:0] sleep_reg;
  reg link_en_reg;
  reg [15:0] frame_count_reg;
  reg [15:0] last_frame_reg;
  reg wr_pend_reg;
  reg [11:0] wr_addr_reg;
  wire frame_valid;
  wire [15:0] frame;
  wire load_ctrl_hi = frame[`LOAD_HI_POS];
  wire load_ctrl_lo = frame[`LOAD_LO_POS];
  wire [1:0] chan_pick = {frame[`PICK_HI_POS], frame[`PICK_LO_POS]};
  wire [CODE_W-1:0] conversion_word = frame[CODE_W-1:0];
  // frames arriving while the link is disabled are dropped whole
  wire take = frame_valid & link_en_reg;
  wire bus_go = hsel_i & hready_i & htrans_i[1];
  integer i;
  genvar g;
  wire [4*CODE_W-1:0] dac_flat;
  wire [7:0] term_flat;

  // one-hot channel mask for a two-bit select
  function [3:0] chan_mask;
    input [1:0] sel;
    begin
      chan_mask = 4'h1 << sel;
    end
  endfunction

  // mode 11 has no termination of its own and falls back to hi-z
  function [1:0] term_code;
    input [1:0] mode;
    begin
      term_code = (mode == 2'h3) ? `TERM_HIZ : mode;
    end
  endfunction

  // register read mux; unmapped offsets read as zero
  function [31:0] read_word;
    input [11:0] addr;
    begin
      read_word = 32'h0000_0000;
      if ((addr & 12'hff0) == `ADDR_INPUT_A)
        read_word = {{(32-CODE_W){1'b0}}, input_mem[addr[3:2]]};
      else if ((addr & 12'hff0) == `ADDR_DAC_A)
        read_word = {{(32-CODE_W){1'b0}}, dac_mem[addr[3:2]]};
      else if (addr == `ADDR_STATUS)
        read_word = {term_o, frame_count_reg, 4'h0, sleep_reg};
      else if (addr == `ADDR_CTRL)
        read_word = {31'h00000000, link_en_reg};
      else if (addr == `ADDR_LAST)
        read_word = {16'h0000, last_frame_reg};
    end
  endfunction

  serial_frame_rx #(
    .BITS(`FRAME_BITS)
  ) rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .sclk_i(sclk_i),
    .frame_strobe_n_i(frame_strobe_n_i),
    .din_i(din_i),
    .frame_valid_o(frame_valid),
    .frame_o(frame)
  );

  // command decode; rx holds the frame, so it is decoded in the cycle of frame_valid
  reg [3:0] wr_input;
  reg [3:0] wr_dac_data;
  reg [3:0] wr_dac_copy;
  reg sleep_cmd;
  always @* begin
    wr_input = 4'h0;
    wr_dac_data = 4'h0;
    wr_dac_copy = 4'h0;
    sleep_cmd = 1'b0;
    if (take) begin
      case ({load_ctrl_hi, load_ctrl_lo})
        2'h0: wr_input = chan_mask(chan_pick);
        2'h1: wr_dac_copy = chan_mask(chan_pick);
        2'h2: begin
          wr_input = chan_mask(chan_pick);
          wr_dac_data = chan_mask(chan_pick);
        end
        default: begin
          case (chan_pick)
            2'h0: wr_input = 4'hf;
            2'h1: wr_dac_copy = 4'hf;
            2'h2: begin
              wr_input = 4'hf;
              wr_dac_data = 4'hf;
            end
            default: sleep_cmd = 1'b1;
          endcase
        end
      endcase
    end
  end

  wire [3:0] sleep_sel = frame[`SLEEP_ALL_POS] ? 4'hf :
    chan_mask({frame[`SLEEP_CHAN_HI], frame[`SLEEP_CHAN_LO]});
  wire [1:0] sleep_mode = {frame[`SLEEP_MODE_HI], frame[`SLEEP_MODE_LO]};
  wire [1:0] sleep_term = term_code(sleep_mode);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        input_mem[i] <= `CODE_RESET;
        dac_mem[i] <= `CODE_RESET;
        term_mem[i] <= `TERM_HIZ;
      end
      sleep_reg <= {4{`SLEEP_RESET}};
      frame_count_reg <= 16'h0000;
      last_frame_reg <= 16'h0000;
    end else if (ce_i) begin
      if (take) begin
        frame_count_reg <= frame_count_reg + 16'h0001;
        last_frame_reg <= frame;
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (wr_input[i])
          input_mem[i] <= conversion_word;
        // outputs move only via the dac register
        if (wr_dac_data[i])
          dac_mem[i] <= conversion_word;
        else if (wr_dac_copy[i])
          dac_mem[i] <= input_mem[i];
        // a dac write wakes the channel
        if (sleep_cmd && sleep_sel[i]) begin
          sleep_reg[i] <= 1'b1;
          term_mem[i] <= sleep_term;
        end else if (wr_dac_data[i] || wr_dac_copy[i]) begin
          sleep_reg[i] <= 1'b0;
        end
      end
    end
  end

  // flatten the per-channel registers onto the output buses
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      assign dac_flat[g*CODE_W +: CODE_W] = dac_mem[g];
      assign term_flat[g*2 +: 2] = term_mem[g];
    end
  endgenerate

  // outputs registered
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dac_code_o <= {4*CODE_W{1'b0}};
      sleep_o <= 4'h0;
      term_o <= 8'h00;
    end else if (ce_i) begin
      dac_code_o <= dac_flat; // unsigned code
      term_o <= term_flat;
      sleep_o <= sleep_reg;
    end
  end

  // ahb-lite slave, zero wait states; registers read-only except ctrl
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      link_en_reg <= 1'b1;
    end else if (ce_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      // write data follows its address phase by one cycle
      if (wr_pend_reg && wr_addr_reg == `ADDR_CTRL)
        link_en_reg <= hwdata_i[0];
      wr_pend_reg <= bus_go & hwrite_i;
      wr_addr_reg <= haddr_i[11:0];
      // hsize is ignored: input and dac reads ignore addr[1:0]; other registers need aligned words
      if (bus_go && !hwrite_i)
        hrdata_o <= read_word(haddr_i[11:0]);
    end
  end
endmodule
`default_nettype wire

// [test/quad_dac_props.sv]
`default_nettype none
module quad_dac_props #(
  parameter CODE_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic frame_strobe_n_i,
  input wire logic hsel_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [1:0] htrans_i,
  input wire logic [31:0] haddr_i,
  input wire logic [31:0] hrdata_o,
  input wire logic [4*CODE_W-1:0] dac_code_o,
  input wire logic [3:0] sleep_o,
  input wire logic [7:0] term_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  property p_ready; hreadyout_o && !hresp_o; endproperty
  a_ready: assert property (p_ready) else $error("bus not ready okay");
  property p_rst; $fell(rst_i) |-> dac_code_o == 0 && sleep_o == 0 && term_o == 0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  property p_idle_dac; frame_strobe_n_i [*8] |-> $stable(dac_code_o); endproperty
  a_idle_dac: assert property (p_idle_dac) else $error("code moved between frames");
  property p_idle_sleep; frame_strobe_n_i [*8] |-> $stable(sleep_o) && $stable(term_o); endproperty
  a_idle_sleep: assert property (p_idle_sleep) else $error("sleep moved between frames");
  property p_term; !(&term_o[1:0] || &term_o[3:2] || &term_o[5:4] || &term_o[7:6]); endproperty
  a_term: assert property (p_term) else $error("bad termination code");
  property p_unmapped; rd_take && haddr_i[11:0] == 12'h02c |=> hrdata_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_freeze; !ce_i |=> $stable(dac_code_o) && $stable(sleep_o); endproperty
  a_freeze: assert property (p_freeze) else $error("moved with enable low");
  property p_hold; !rd_take |=> $stable(hrdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  c_dac: cover property ($changed(dac_code_o));
  c_sleep: cover property ($rose(|sleep_o));
  c_read: cover property (rd_take);
endmodule
`default_nettype wire

// [test/quad_dac_host_model.sv]
`default_nettype none
module quad_dac_host_model (
  output logic sclk_o,
  output logic strobe_n_o,
  output logic din_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {sclk_o, strobe_n_o, din_o} = 3'h6;
  // link clock rests high between frames; released data shows its inverse
  task automatic send(input logic [15:0] w);
    #3 strobe_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din_o = w[i];
      #80 sclk_o = 1'b0;
      #80 sclk_o = 1'b1;
    end
    #80 strobe_n_o = 1'b1;
    din_o = ~din_o;
    #200;
  endtask
endmodule
`default_nettype wire

// [test/quad_dac_serial_load_control_bench.sv]
`default_nettype none
module quad_dac_serial_load_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, rst_i = 1, ce_i = 1, hwrite_i = 0, on = 1, sclk_i, frame_strobe_n_i, din_i, hreadyout_o;
  logic [1:0] htrans_i = 0, m;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd;
  logic [47:0] dac_code_o;
  logic [7:0] term_o, tm = 0;
  logic [3:0] sleep_o, sl = 0;
  logic [11:0] ir [4] = '{default: 0}, dr [4] = '{default: 0};
  logic [15:0] seq [9] = '{16'h09a0, 16'h19a1, 16'h29a2, 16'h39a3, 16'h5123, 16'hbfff, 16'hc456, 16'hd000, 16'he7ff};
  int errors = 0, compares = 0, cyc = 0;
  quad_dac_host_model host (.sclk_o(sclk_i), .strobe_n_o(frame_strobe_n_i), .din_o(din_i));
  quad_dac_serial_load_control dut (.clk_i, .rst_i, .ce_i, .sclk_i, .frame_strobe_n_i, .din_i, .hsel_i(1'b1),
    .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
    .hresp_o(), .dac_code_o, .sleep_o, .term_o);
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc > 9000) begin
    errors++;
    wrap_up;
  end
  task automatic chk(input string n, input logic [59:0] e, g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans_i <= 2'h2;
    haddr_i <= 32'(a);
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  // reference update: broadcast codes reuse the single-channel modes
  task automatic frame(input logic [15:0] w);
    m = &w[15:14] ? w[13:12] : w[15:14];
    host.send(w);
    for (int c = 0; c < 4; c++) if (on && (&w[15:14] || w[13:12] == c)) begin
      if (m == 3 && (w[11] || w[10:9] == c)) begin
        sl[c] = 1'b1;
        tm[2*c+:2] = &w[8:7] ? 2'h0 : w[8:7];
      end
      if (m == 1 || m == 2) sl[c] = 1'b0;
      if (!m[0]) ir[c] = w[11:0];
      if (m == 2) dr[c] = w[11:0];
      if (m == 1) dr[c] = ir[c];
    end
    @(posedge clk_i);
    chk("code", {dr[3], dr[2], dr[1], dr[0]}, dac_code_o);
    chk("sleep", sl, sleep_o);
    if (m == 3) chk("term", tm, term_o);
  endtask
  task automatic t_load;
    chk("reset", 0, {term_o, sleep_o, dac_code_o});
    foreach (seq[i]) begin
      frame(seq[i]);
      bus(1'b0, 12'(4 * (i % 4)), 0);
      chk("input", ir[i % 4], rd);
      bus(1'b0, 12'(16 + 4 * (i % 4)), 0);
      chk("dac reg", dr[i % 4], rd);
    end
    $display("load test done");
  endtask
  task automatic t_sleep;
    for (int i = 0; i < 8; i++) frame({4'hf, i[2], i[1:0], i[1:0], 7'h0});
    frame(16'h2abc);
    $display("sleep test done");
  endtask
  task automatic t_bus;
    bus(1'b0, 12'h024, 0);
    chk("ctrl", 1, rd);
    bus(1'b1, 12'h024, 0);
    on = 0;
    frame(16'h6111);
    bus(1'b1, 12'h024, 1);
    on = 1;
    bus(1'b0, 12'h02c, 0);
    chk("unmapped", 0, rd);
    bus(1'b0, 12'h028, 0);
    chk("last", 16'h2abc, rd);
    ce_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    frame(16'h6111);
    bus(1'b0, 12'h020, 0);
    chk("status", {tm, 16'h0013, 4'h0, sl}, rd);
    $display("bus test done");
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_load;
    t_sleep;
    t_bus;
    wrap_up;
  end
endmodule
bind quad_dac_serial_load_control quad_dac_props #(.CODE_W(CODE_W)) props (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .ce_i(ce_i),
  .frame_strobe_n_i(frame_strobe_n_i),
  .hsel_i(hsel_i),
  .hwrite_i(hwrite_i),
  .hready_i(hready_i),
  .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o),
  .htrans_i(htrans_i),
  .haddr_i(haddr_i),
  .hrdata_o(hrdata_o),
  .dac_code_o(dac_code_o),
  .sleep_o(sleep_o),
  .term_o(term_o)
);
`default_nettype wire
